// ---- rtl/rf_osc_defs.svh ----
// offsets, field positions and reset values of the rf/oscillator registers
`ifndef RF_OSC_DEFS_SVH
`define RF_OSC_DEFS_SVH

`define OFS_CRYSTAL_BIAS_CONTROL    8'h86
`define OFS_OSCILLATOR_PLL_STATUS   8'he3
`define OFS_AMPLIFIER_POWER_CONTROL 8'hf1
`define OFS_AMPLIFIER_BIAS_LEVEL    8'hf2

`define POS_OSC_RUNNING   4
`define POS_VCO_GAIN      3
`define POS_SYNTH_LOCK    2
`define POS_PA_SUPPLY     7
`define POS_PREDRV_HI     5
`define POS_PREDRV_LO     0

`define RST_OSC_BIAS      4'h0
`define RST_PA_CTRL       8'h00
`define RST_PA_LEVEL      8'h00
`define RST_STATUS        8'h00

`endif

// ---- rtl/rf_osc_pkg.sv ----
// types shared by the rf/oscillator register bank
package rf_osc_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] predrv_t;
endpackage

// ---- rtl/rf_osc_control_regs.sv ----
// register bank for crystal oscillator and rf power amplifier control
`timescale 1ns/1ps
`include "rf_osc_defs.svh"

module rf_osc_control_regs
    import rf_osc_pkg::*;
(
    input  wire logic       MCLK_I,
    input  wire logic       ARST_N_I,
    input  wire logic       TMR_RST_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic       OSC_RUNNING_I,
    input  wire logic       VCO_GAIN_I,
    input  wire logic       SYNTH_LOCK_I,
    output logic      [7:0] RDATA_O,
    output logic      [3:0] OSC_BIAS_CODE_O,
    output logic            PA_SUPPLY_ON_O,
    output logic      [1:0] PREDRIVER_CURRENT_CODE_O,
    output logic      [7:0] PA_OUTPUT_LEVEL_O
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic       rst_s1_reg;
    logic       rst_n_reg;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // analog status synchronisers
    // ------------------------------------------------------------
    // three stages; a change counts once stages two and three agree
    logic [2:0] st_s1_reg;
    logic [2:0] st_s2_reg;
    logic [2:0] st_s3_reg;
    logic [2:0] st_reg;

    always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            st_s1_reg <= 3'h0;
            st_s2_reg <= 3'h0;
            st_s3_reg <= 3'h0;
        end else begin
            st_s1_reg <= {OSC_RUNNING_I, VCO_GAIN_I, SYNTH_LOCK_I};
            st_s2_reg <= st_s1_reg;
            st_s3_reg <= st_s2_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_filt
            always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    st_reg[g] <= 1'b0;
                end else if (st_s2_reg[g] == st_s3_reg[g]) begin
                    st_reg[g] <= st_s3_reg[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // write-only control registers
    // ------------------------------------------------------------
    logic       wr_bias;
    logic       wr_pa;
    logic       wr_lvl;

    assign wr_bias = WR_I && (ADDR_I == `OFS_CRYSTAL_BIAS_CONTROL);
    assign wr_pa   = WR_I && (ADDR_I == `OFS_AMPLIFIER_POWER_CONTROL);
    assign wr_lvl  = WR_I && (ADDR_I == `OFS_AMPLIFIER_BIAS_LEVEL);

    // upper nibble has no storage; written bits are dropped
    always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            OSC_BIAS_CODE_O <= `RST_OSC_BIAS;
        end else if (TMR_RST_I) begin
            OSC_BIAS_CODE_O <= `RST_OSC_BIAS;
        end else if (wr_bias) begin
            OSC_BIAS_CODE_O <= WDATA_I[3:0];
        end
    end

    // reserved bits of the amp control word are not kept
    always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            PA_SUPPLY_ON_O           <= 1'b0;
            PREDRIVER_CURRENT_CODE_O <= 2'h0;
        end else if (TMR_RST_I) begin
            PA_SUPPLY_ON_O           <= 1'(`RST_PA_CTRL >> `POS_PA_SUPPLY);
            PREDRIVER_CURRENT_CODE_O <= 2'h0;
        end else if (wr_pa) begin
            PA_SUPPLY_ON_O           <= WDATA_I[`POS_PA_SUPPLY];
            PREDRIVER_CURRENT_CODE_O <= {WDATA_I[`POS_PREDRV_HI],
                                         WDATA_I[`POS_PREDRV_LO]};
        end
    end

    always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            PA_OUTPUT_LEVEL_O <= `RST_PA_LEVEL;
        end else if (TMR_RST_I) begin
            PA_OUTPUT_LEVEL_O <= `RST_PA_LEVEL;
        end else if (wr_lvl) begin
            PA_OUTPUT_LEVEL_O <= WDATA_I;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // write-only registers read as zero; only status is visible
    byte_t status_next;

    always_comb begin
        status_next                    = `RST_STATUS;
        status_next[`POS_OSC_RUNNING]  = st_reg[2];
        status_next[`POS_VCO_GAIN]     = st_reg[1];
        status_next[`POS_SYNTH_LOCK]   = st_reg[0];
    end

    always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            RDATA_O <= 8'h00;
        end else if (RD_I && (ADDR_I == `OFS_OSCILLATOR_PLL_STATUS)) begin
            RDATA_O <= status_next;
        end else begin
            RDATA_O <= 8'h00;
        end
    end

endmodule

// ---- sim/rf_osc_control_regs_assertions.sv ----
// concurrent checks on the rf/oscillator register bank ports
`timescale 1ns/1ps
module rf_osc_control_regs_assertions (
    input wire logic       MCLK_I, ARST_N_I, TMR_RST_I, WR_I, RD_I,
    input wire logic       OSC_RUNNING_I, VCO_GAIN_I, SYNTH_LOCK_I,
    input wire logic [7:0] ADDR_I, WDATA_I, RDATA_O, PA_OUTPUT_LEVEL_O,
    input wire logic [3:0] OSC_BIAS_CODE_O,
    input wire logic       PA_SUPPLY_ON_O,
    input wire logic [1:0] PREDRIVER_CURRENT_CODE_O
);
    wire logic w86 = WR_I && ADDR_I == 8'h86 && !TMR_RST_I;
    wire logic wf1 = WR_I && ADDR_I == 8'hf1 && !TMR_RST_I;
    wire logic wf2 = WR_I && ADDR_I == 8'hf2 && !TMR_RST_I;
    wire logic re3 = RD_I && ADDR_I == 8'he3;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    AST_BIAS_WR: assert property (w86 |=> OSC_BIAS_CODE_O == $past(WDATA_I[3:0])) else $error("bias write lost");
    AST_BIAS_HOLD: assert property (!w86 && !TMR_RST_I |=> $stable(OSC_BIAS_CODE_O)) else $error("bias moved");
    AST_OSC: assert property ($stable(OSC_RUNNING_I)[*8] ##0 re3 |=> RDATA_O[4] == $past(OSC_RUNNING_I)) else $error("osc flag");
    AST_VCO: assert property ($stable(VCO_GAIN_I)[*8] ##0 re3 |=> RDATA_O[3] == $past(VCO_GAIN_I)) else $error("vco flag");
    AST_LOCK: assert property ($stable(SYNTH_LOCK_I)[*8] ##0 re3 |=> RDATA_O[2] == $past(SYNTH_LOCK_I)) else $error("lock flag");
    AST_PA_ON: assert property (wf1 |=> PA_SUPPLY_ON_O == $past(WDATA_I[7])) else $error("pa supply");
    AST_PREDRV: assert property (wf1 |=> PREDRIVER_CURRENT_CODE_O == {$past(WDATA_I[5]), $past(WDATA_I[0])}) else $error("predriver");
    AST_LEVEL: assert property (wf2 |=> PA_OUTPUT_LEVEL_O == $past(WDATA_I)) else $error("pa level");
    AST_TMR_CLR: assert property (TMR_RST_I |=> !PA_SUPPLY_ON_O && PREDRIVER_CURRENT_CODE_O == 2'h0 && PA_OUTPUT_LEVEL_O == 8'h00 && OSC_BIAS_CODE_O == 4'h0) else $error("timer clear");
endmodule
bind rf_osc_control_regs rf_osc_control_regs_assertions rf_osc_control_regs_assertions_i (.*);

// ---- sim/rf_osc_control_regs_bench.sv ----
// self-checking bench for the rf/oscillator register bank
`timescale 1ns/1ps
module rf_osc_control_regs_bench;
    import rf_osc_pkg::*;
    logic       clk = 0, rst_n = 0, tmr = 0, wr = 0, rd = 0, pa;
    logic [2:0] st = 0;
    logic [3:0] bias;
    byte_t      a = 0, d = 0, rdata, lvl;
    byte_t      adr[5] = '{8'h86, 8'he3, 8'hf1, 8'hf2, 8'h55};
    predrv_t    pre;
    int         fails = 0, n_checks = 0, m_bias = 0, m_ctl = 0, m_lvl = 0, i;
    always #12.5 clk = ~clk;
    rf_osc_control_regs rf_osc_control_regs_i (.MCLK_I(clk), .ARST_N_I(rst_n),
        .TMR_RST_I(tmr), .ADDR_I(a), .WDATA_I(d), .WR_I(wr), .RD_I(rd),
        .OSC_RUNNING_I(st[2]), .VCO_GAIN_I(st[1]), .SYNTH_LOCK_I(st[0]),
        .RDATA_O(rdata), .OSC_BIAS_CODE_O(bias), .PA_SUPPLY_ON_O(pa),
        .PREDRIVER_CURRENT_CODE_O(pre), .PA_OUTPUT_LEVEL_O(lvl));
    task automatic chk(string n, byte_t e, byte_t s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic outs();
        chk("bias", 8'(m_bias[3:0]), {4'h0, bias});
        chk("pa", 8'(m_ctl[7]), {7'h0, pa});
        chk("pre", {6'h0, m_ctl[5], m_ctl[0]}, {6'h0, pre});
        chk("level", m_lvl[7:0], lvl);
    endtask
    // strobe held over one rising edge, result looked at one edge later
    task automatic op(logic w, byte_t ad, byte_t dt);
        @(negedge clk);
        {wr, rd, a, d} = {w, !w, ad, dt};
        @(negedge clk);
        {wr, rd} = 2'b00;
        if (w && ad == 8'h86) m_bias = dt[3:0];
        if (w && ad == 8'hf1) m_ctl = dt;
        if (w && ad == 8'hf2) m_lvl = dt;
        if (!w) chk("rdata", ad == 8'he3 ? {3'h0, st, 2'h0} : 8'h00, rdata);
        outs();
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h53af8249));
        repeat (6) @(negedge clk);
        rst_n = 1;
        repeat (12) @(negedge clk);
        outs();
        $display("test reset values done");
        for (i = 0; i < 80; i++) begin
            // status is synchronised and filtered, so let it settle first
            st = 3'($urandom);
            repeat (8) @(negedge clk);
            op(1'($urandom), adr[$urandom % 5], 8'($urandom));
        end
        $display("test random access done");
        op(1, 8'hf1, 8'hff);
        op(1, 8'h86, 8'h0f);
        @(negedge clk);
        {tmr, wr, a, d} = {2'b11, 8'hf2, 8'h7e};
        @(negedge clk);
        {tmr, wr} = 2'b00;
        {m_bias, m_ctl, m_lvl} = 0;
        outs();
        $display("test timer reset done");
        give_verdict();
    end
endmodule
